// ===== bench/slave_serial_config_port_bench.sv
// Bench joining host and device ends over one link
`timescale 1ns/1ps

module slave_serial_config_port_bench;
   localparam int PRE = 16;
   localparam int CFG = 72;
   logic clk_sys_i;
   logic sys_rst_i;
   logic [7:0] tx_data;
   logic tx_valid;
   logic tx_ready;
   logic init_high;
   logic [7:0] cfg_data;
   logic cfg_valid;
   logic cfg_ready;
   logic cfg_done;
   logic cfg_error;
   logic rdy_en;
   logic fwd_en;
   int err_count;
   int samples_checked;
   int bit_n;
   int edge_n;
   logic exp_bit_q[$];
   logic [7:0] exp_byte_q[$];

   ssc_link_if ssc_link_if_i();
   ssc_host_end ssc_host_end_i(.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .link(ssc_link_if_i.host), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready), .init_high_o(init_high));
   ssc_device_end #(.PREAMBLE_BITS(PRE), .CONFIG_BITS(CFG)) ssc_device_end_i(
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .link(ssc_link_if_i.dev), .cfg_data_o(cfg_data),
      .cfg_valid_o(cfg_valid), .cfg_ready_i(cfg_ready),
      .cfg_done_o(cfg_done), .cfg_error_o(cfg_error));
   ssc_link_checker #(.PREAMBLE_BITS(PRE)) ssc_link_checker_i(
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .config_shift_clock(ssc_link_if_i.config_shift_clock),
      .serial_din(ssc_link_if_i.serial_din),
      .serial_dout(ssc_link_if_i.serial_dout),
      .mode_pullup_en(ssc_link_if_i.mode_pullup_en),
      .mode_select_hi(ssc_link_if_i.mode_select_hi),
      .mode_select_mid(ssc_link_if_i.mode_select_mid),
      .mode_select_lo(ssc_link_if_i.mode_select_lo),
      .init_dev_o(ssc_link_if_i.init_dev_o),
      .init_dev_oe(ssc_link_if_i.init_dev_oe),
      .init_host_o(ssc_link_if_i.init_host_o),
      .init_host_oe(ssc_link_if_i.init_host_oe),
      .init_lvl(ssc_link_if_i.init_lvl));

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic check(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   task automatic complete_run();
      $display("mismatches %0d of %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic reset_link();
      sys_rst_i <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      exp_bit_q.delete();
      exp_byte_q.delete();
      bit_n = 0;
      edge_n = 0;
      repeat (2) @(posedge clk_sys_i);
      check(ssc_link_if_i.init_lvl === 1'b0, "init not held low");
   endtask

   // Own bits show idle level on the chain; the rest pass through
   task automatic send_byte(input logic [7:0] b, input logic fwd);
      int n;
      n = 0;
      tx_data <= b;
      tx_valid <= 1'b1;
      @(posedge clk_sys_i);
      while (tx_ready !== 1'b1) begin
         n++;
         if (n > 3000) begin
            check(1'b0, "byte never taken");
            complete_run();
         end
         @(posedge clk_sys_i);
      end
      tx_valid <= 1'b0;
      // Let an edge pass so a following call never re-drives valid at once
      @(posedge clk_sys_i);
      if (fwd && bit_n >= PRE && bit_n < PRE + CFG) begin
         exp_byte_q.push_back(b);
      end
      for (int k = 7; k >= 0; k--) begin
         if (fwd) begin
            exp_bit_q.push_back((bit_n < PRE || bit_n >= PRE + CFG) ?
                                b[k] : 1'b1);
         end
         bit_n++;
      end
   endtask

   // Downstream view: sample the chain output on each rising edge after the first
   always @(posedge ssc_link_if_i.config_shift_clock) begin
      if (fwd_en && edge_n > 0 && exp_bit_q.size() > 0) begin
         check(ssc_link_if_i.serial_dout ===
               exp_bit_q.pop_front(), "chain bit");
      end
      edge_n++;
   end

   always @(posedge clk_sys_i) begin
      cfg_ready <= rdy_en && ($urandom % 2 == 1);
      if (cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
         if (exp_byte_q.size() == 0) begin
            check(1'b0, "extra config byte");
         end else begin
            check(cfg_data === exp_byte_q.pop_front(), "config byte");
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(33));
      sys_rst_i = 1'b1;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      cfg_ready = 1'b0;
      rdy_en = 1'b1;
      fwd_en = 1'b1;
      err_count = 0;
      samples_checked = 0;
      reset_link();
      // Preamble, own bits with a stalling reader, then overflow bits
      repeat (13) send_byte(8'($urandom), 1'b1);
      repeat (300) @(posedge clk_sys_i);
      check(cfg_done === 1'b1, "not done");
      check(cfg_error === 1'b0, "false error");
      check(exp_byte_q.size() == 0, "config bytes missing");
      check(init_high === 1'b1, "host lost init");
      // Reader never drains, so the ninth own byte overruns the buffer
      rdy_en = 1'b0;
      fwd_en = 1'b0;
      reset_link();
      repeat (11) send_byte(8'($urandom), 1'b0);
      repeat (150) @(posedge clk_sys_i);
      check(cfg_error === 1'b1, "overrun missed");
      check(ssc_link_if_i.init_lvl === 1'b0, "init released");
      complete_run();
   end
endmodule

// ===== bench/ssc_link_checker.sv
// Timing assertions on the pins of the serial configuration link
`timescale 1ns/1ps

module ssc_link_checker #(
   parameter int PREAMBLE_BITS = 40
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // Link pins
   input wire logic config_shift_clock,
   input wire logic serial_din,
   input wire logic serial_dout,
   input wire logic mode_pullup_en,
   input wire logic mode_select_hi,
   input wire logic mode_select_mid,
   input wire logic mode_select_lo,
   input wire logic init_dev_o,
   input wire logic init_dev_oe,
   input wire logic init_host_o,
   input wire logic init_host_oe,
   input wire logic init_lvl
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   logic sclk_q;
   logic [15:0] rise_cnt_q;

   always_ff @(posedge clk_sys_i) begin
      sclk_q <= config_shift_clock;
   end

   // Saturates so a long run never wraps back into the preamble
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rise_cnt_q <= 16'h0000;
      end else if (config_shift_clock && !sclk_q &&
                   rise_cnt_q != 16'hffff) begin
         rise_cnt_q <= rise_cnt_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence rise_s;
      $rose(config_shift_clock);
   endsequence

   sequence pre_rise_s;
      $rose(config_shift_clock) && rise_cnt_q < 16'(PREAMBLE_BITS);
   endsequence

   a_sclk_high: assert property (
      rise_s |-> config_shift_clock[*5] ##1 !config_shift_clock)
      else $error("shift clock high phase wrong");
   a_sclk_low: assert property (
      $fell(config_shift_clock) |-> !config_shift_clock[*5])
      else $error("shift clock low phase short");
   a_din_steady: assert property (
      rise_s |-> ($past(serial_din) == serial_din) ##1
      $stable(serial_din)[*3])
      else $error("data moved around capture edge");
   a_mode_slave: assert property (
      rise_s |-> {mode_select_hi, mode_select_mid, mode_select_lo} == 3'h7)
      else $error("mode pins not slave serial");
   // Pull-up must stay on from reset through the whole preamble
   a_pullup_on: assert property (
      ($past(sys_rst_i) || rise_cnt_q < 16'(PREAMBLE_BITS)) |->
      mode_pullup_en)
      else $error("mode pull-up off during load");
   a_dout_on_fall: assert property (
      $changed(serial_dout) |-> !config_shift_clock &&
      !$past(config_shift_clock) && ($past(config_shift_clock, 3) ||
      $past(config_shift_clock, 4) || $past(config_shift_clock, 5)))
      else $error("chain output changed off falling edge");
   a_pre_forward: assert property (
      pre_rise_s |-> ##10 (serial_dout == $past(serial_din, 10)))
      else $error("preamble bit not forwarded");
   a_init_gate: assert property (
      rise_s |-> $past(init_lvl, 3))
      else $error("clocking while init low");
   a_init_clear: assert property (
      $past(sys_rst_i) |-> !init_lvl[*8])
      else $error("init released too soon");
   a_init_drain: assert property (
      (init_dev_oe |-> !init_dev_o) and (init_host_oe |-> !init_host_o))
      else $error("init driven high");
endmodule

// ===== hw/ssc_defs.svh
// Constants shared by both ends of the slave serial configuration link
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

`define SSC_MODE_SLAVE_SERIAL 3'b111
`define SSC_SYS_PERIOD_NS 10
`define SSC_SCLK_HIGH_NS 45
`define SSC_SCLK_LOW_NS 45
`define SSC_SCLK_HIGH_CYC \
   ((`SSC_SCLK_HIGH_NS + `SSC_SYS_PERIOD_NS - 1) / `SSC_SYS_PERIOD_NS)
`define SSC_SCLK_LOW_CYC \
   ((`SSC_SCLK_LOW_NS + `SSC_SYS_PERIOD_NS - 1) / `SSC_SYS_PERIOD_NS)
`define SSC_INIT_CLEAR_CYC 16
`define SSC_PREAMBLE_BITS 40
`define SSC_CONFIG_BITS 64
`define SSC_BYTE_BITS 8
`define SSC_FIFO_DEPTH 8
`define SSC_DOUT_IDLE 1'b1

`endif

// ===== hw/ssc_device_end.sv
// Configured device end: serial capture, chain forwarding, byte FIFO
`timescale 1ns/1ps
`include "ssc_defs.svh"

module ssc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `SSC_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // Fill side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // Drain side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      if (p == AW'(DEPTH - 1)) begin
         return '0;
      end
      return p + AW'(1);
   endfunction

   // Head register counts toward the depth, so at most DEPTH words wait
   assign in_ready_o = (count_q + (AW+1)'(out_valid_o)) < (AW+1)'(DEPTH);
   assign push = in_valid_i && in_ready_o;
   // Head register refills whenever it is empty or being taken
   assign pop = (count_q != '0) && (!out_valid_o || out_ready_i);

   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= ptr_inc(wr_ptr_q);
         end
         if (pop) begin
            rd_ptr_q <= ptr_inc(rd_ptr_q);
         end
         if (push && !pop) begin
            count_q <= count_q + (AW+1)'(1);
         end else if (pop && !push) begin
            count_q <= count_q - (AW+1)'(1);
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end else if (pop) begin
         out_valid_o <= 1'b1;
         out_data_o <= mem[rd_ptr_q];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////

module ssc_device_end
   import ssc_pkg::*;
#(
   parameter int PREAMBLE_BITS = `SSC_PREAMBLE_BITS,
   parameter int CONFIG_BITS = `SSC_CONFIG_BITS,
   parameter int FIFO_DEPTH = `SSC_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // Link pins
   ssc_link_if.dev link,
   // Captured configuration bytes
   output logic [`SSC_BYTE_BITS-1:0] cfg_data_o,
   output logic cfg_valid_o,
   input wire logic cfg_ready_i,
   // Status
   output logic cfg_done_o,
   output logic cfg_error_o
);
   dev_state_t state_q;
   logic [2:0] sclk_sync_q;
   logic [1:0] din_sync_q;
   logic [2:0] mode_s1_q;
   logic [2:0] mode_s2_q;
   logic [7:0] clear_cnt_q;
   logic [31:0] bit_cnt_q;
   logic [`SSC_BYTE_BITS-1:0] byte_q;
   logic [3:0] nbit_q;
   logic push_q;
   logic fwd_bit_q;
   logic dout_q;
   logic init_low_q;
   logic pullup_q;
   logic fifo_ready;
   logic sclk_rise;
   logic sclk_fall;
   logic slave_mode;
   logic own_bit;

   // Link clock is only sampled; it is never generated here
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         sclk_sync_q <= '0;
         din_sync_q <= '0;
         mode_s1_q <= '0;
         mode_s2_q <= '0;
      end else begin
         sclk_sync_q <= {sclk_sync_q[1:0], link.config_shift_clock};
         din_sync_q <= {din_sync_q[0], link.serial_din};
         mode_s1_q <= {link.mode_select_hi, link.mode_select_mid,
                       link.mode_select_lo};
         mode_s2_q <= mode_s1_q;
      end
   end

   // Data shares the clock's sync depth, so it lines up with the edge
   assign sclk_rise = sclk_sync_q[1] && !sclk_sync_q[2];
   assign sclk_fall = !sclk_sync_q[1] && sclk_sync_q[2];
   assign slave_mode = (mode_s2_q == `SSC_MODE_SLAVE_SERIAL);
   assign own_bit = (state_q == DEV_LOAD) &&
                    (bit_cnt_q >= 32'(PREAMBLE_BITS));

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_q <= DEV_CLEAR;
         clear_cnt_q <= '0;
      end else begin
         case (state_q)
            DEV_CLEAR: begin
               clear_cnt_q <= clear_cnt_q + 8'h01;
               if (clear_cnt_q == 8'(`SSC_INIT_CLEAR_CYC - 1)) begin
                  state_q <= DEV_LOAD;
               end
            end
            DEV_LOAD: begin
               if (push_q && !fifo_ready) begin
                  state_q <= DEV_ERROR;
               end else if (bit_cnt_q ==
                            32'(PREAMBLE_BITS + CONFIG_BITS)) begin
                  state_q <= DEV_DONE;
               end
            end
            default: begin
               state_q <= state_q;
            end
         endcase
      end
   end

   // Bit capture on the rising edge, in slave serial mode only
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         bit_cnt_q <= '0;
         byte_q <= '0;
         nbit_q <= '0;
         push_q <= 1'b0;
         fwd_bit_q <= `SSC_DOUT_IDLE;
      end else begin
         push_q <= 1'b0;
         if (sclk_rise && slave_mode && state_q != DEV_CLEAR &&
             state_q != DEV_ERROR) begin
            if (state_q == DEV_LOAD) begin
               bit_cnt_q <= bit_cnt_q + 32'h0000_0001;
            end
            if (own_bit) begin
               byte_q <= {byte_q[`SSC_BYTE_BITS-2:0], din_sync_q[1]};
               fwd_bit_q <= `SSC_DOUT_IDLE;
               if (nbit_q == 4'(`SSC_BYTE_BITS - 1)) begin
                  nbit_q <= '0;
                  push_q <= 1'b1;
               end else begin
                  nbit_q <= nbit_q + 4'h1;
               end
            end else begin
               fwd_bit_q <= din_sync_q[1];
            end
         end
      end
   end

   // Output changes half a period later, on the falling edge
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         dout_q <= `SSC_DOUT_IDLE;
      end else if (sclk_fall) begin
         dout_q <= fwd_bit_q;
      end
   end

   // Init held low while clearing or after an overrun, never driven high
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         init_low_q <= 1'b1;
         pullup_q <= 1'b1;
      end else begin
         init_low_q <= (state_q == DEV_CLEAR) || (state_q == DEV_ERROR) ||
                       (push_q && !fifo_ready);
         pullup_q <= (state_q != DEV_DONE);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         cfg_done_o <= 1'b0;
         cfg_error_o <= 1'b0;
      end else begin
         cfg_done_o <= (state_q == DEV_DONE);
         cfg_error_o <= (state_q == DEV_ERROR);
      end
   end

   // A full FIFO cannot stall the external clock, so overrun is fatal
   ssc_fifo #(
      .WIDTH(`SSC_BYTE_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .in_data_i(byte_q),
      .in_valid_i(push_q),
      .in_ready_o(fifo_ready),
      .out_data_o(cfg_data_o),
      .out_valid_o(cfg_valid_o),
      .out_ready_i(cfg_ready_i)
   );

   assign link.serial_dout = dout_q;
   assign link.init_dev_o = 1'b0;
   assign link.init_dev_oe = init_low_q;
   assign link.mode_pullup_en = pullup_q;
endmodule

// ===== hw/ssc_host_end.sv
// Configuring party end: makes the shift clock and sends bytes MSB first
`timescale 1ns/1ps
`include "ssc_defs.svh"

module ssc_host_end
   import ssc_pkg::*;
#(
   parameter int HIGH_CYC = `SSC_SCLK_HIGH_CYC,
   parameter int LOW_CYC = `SSC_SCLK_LOW_CYC
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // Link pins
   ssc_link_if.host link,
   // Bytes to send
   input wire logic [`SSC_BYTE_BITS-1:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   // Status
   output logic init_high_o
);
   host_state_t state_q;
   logic [1:0] init_sync_q;
   logic [7:0] div_q;
   logic [`SSC_BYTE_BITS-1:0] sh_q;
   logic [3:0] left_q;
   logic sclk_q;
   logic din_q;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         init_sync_q <= '0;
         init_high_o <= 1'b0;
      end else begin
         init_sync_q <= {init_sync_q[0], link.init_lvl};
         init_high_o <= init_sync_q[1];
      end
   end

   // Clock made here by dividing the system clock
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_q <= HOST_WAIT_INIT;
         tx_ready_o <= 1'b0;
         div_q <= '0;
         sh_q <= '0;
         left_q <= '0;
         sclk_q <= 1'b0;
         din_q <= 1'b1;
      end else begin
         case (state_q)
            HOST_WAIT_INIT: begin
               if (init_sync_q[1]) begin
                  state_q <= HOST_IDLE;
                  tx_ready_o <= 1'b1;
               end
            end
            HOST_IDLE: begin
               if (tx_valid_i && tx_ready_o) begin
                  tx_ready_o <= 1'b0;
                  sh_q <= {tx_data_i[`SSC_BYTE_BITS-2:0], 1'b0};
                  din_q <= tx_data_i[`SSC_BYTE_BITS-1];
                  left_q <= 4'(`SSC_BYTE_BITS);
                  div_q <= '0;
                  state_q <= HOST_LOW;
               end
            end
            HOST_LOW: begin
               div_q <= div_q + 8'h01;
               if (div_q == 8'(LOW_CYC - 1)) begin
                  div_q <= '0;
                  sclk_q <= 1'b1;
                  state_q <= HOST_HIGH;
               end
            end
            HOST_HIGH: begin
               div_q <= div_q + 8'h01;
               if (div_q == 8'(HIGH_CYC - 1)) begin
                  div_q <= '0;
                  sclk_q <= 1'b0;
                  left_q <= left_q - 4'h1;
                  if (left_q == 4'h1) begin
                     state_q <= HOST_IDLE;
                     tx_ready_o <= 1'b1;
                  end else begin
                     din_q <= sh_q[`SSC_BYTE_BITS-1];
                     sh_q <= {sh_q[`SSC_BYTE_BITS-2:0], 1'b0};
                     state_q <= HOST_LOW;
                  end
               end
            end
            default: begin
               state_q <= HOST_WAIT_INIT;
            end
         endcase
      end
   end

   assign link.config_shift_clock = sclk_q;
   assign link.serial_din = din_q;
   assign link.mode_drv = `SSC_MODE_SLAVE_SERIAL;
   assign link.mode_oe = 1'b1;
   assign link.init_host_o = 1'b0;
   assign link.init_host_oe = 1'b0;
endmodule

// ===== hw/ssc_link_if.sv
// Pin-level link between configuring party and configured device
`timescale 1ns/1ps
interface ssc_link_if;
   logic config_shift_clock;
   logic serial_din;
   logic serial_dout;
   // Mode pins: host drive with enable, device weak pull-up
   logic [2:0] mode_drv;
   logic mode_oe;
   logic mode_pullup_en;
   logic mode_select_hi;
   logic mode_select_mid;
   logic mode_select_lo;
   // Open-drain init line, one enable per party
   logic init_dev_o;
   logic init_dev_oe;
   logic init_host_o;
   logic init_host_oe;
   logic init_lvl;

   // Undriven pin without pull-up reads low in this model
   assign mode_select_hi = mode_oe ? mode_drv[2] : mode_pullup_en;
   assign mode_select_mid = mode_oe ? mode_drv[1] : mode_pullup_en;
   assign mode_select_lo = mode_oe ? mode_drv[0] : mode_pullup_en;
   // External pull-up releases the line high
   assign init_lvl = !((init_dev_oe && !init_dev_o) ||
                       (init_host_oe && !init_host_o));

   modport dev (
      input config_shift_clock,
      input serial_din,
      input mode_select_hi,
      input mode_select_mid,
      input mode_select_lo,
      input init_lvl,
      output serial_dout,
      output mode_pullup_en,
      output init_dev_o,
      output init_dev_oe
   );

   modport host (
      output config_shift_clock,
      output serial_din,
      output mode_drv,
      output mode_oe,
      output init_host_o,
      output init_host_oe,
      input serial_dout,
      input init_lvl
   );
endinterface

// ===== hw/ssc_pkg.sv
// Types shared by both ends of the slave serial configuration link
package ssc_pkg;
   typedef enum logic [2:0] {
      DEV_CLEAR,
      DEV_LOAD,
      DEV_DONE,
      DEV_ERROR
   } dev_state_t;

   typedef enum logic [2:0] {
      HOST_WAIT_INIT,
      HOST_IDLE,
      HOST_LOW,
      HOST_HIGH
   } host_state_t;
endpackage
